/* File: rtl/cantx_top.sv */
/*
 * Control logic of a high-speed CAN transceiver: operating modes, driver
 * control, receive output, slew select, bus wake-up detection and bus
 * short-circuit diagnosis. Configuration arrives as plain level ports from
 * the serial register block; inputs are synchronous to mclk.
 */
// Functional notes
// R1: Transmit-receive mode: driver and receiver both active.
// R2: Receive-only mode: driver off, receiver reports bus.
// R3: Driver enables in Normal mode with recessive input.
// R4: High input recessive bus, low input dominant.
// R5: Receive output high recessive, low dominant.
// R6: Three slew rates, fastest by default.
// R7: Sleep: drivers off, lines grounded, bias released.
// R8: Wake sets flag, pulses interrupt, leaves sleep.
// R9: Back to Normal restores recessive bus levels.
// R10: Wake detection only asleep with wake enabled.
// R11: Pattern wake: three valid pulses within window.
// R12: Valid dominant pulse lasts over 500 ns.
// R13: Single-pulse wake after a 2 us pulse.
// R14: Decode ground comparators into ground faults.
// R15: Decode battery comparators into battery faults.
// R16: Decode rail comparators into rail faults.
// R17: Recessive phase detects, dominant phase locates.
// R18: Report fault after five matching cycles.
// R19: Long dominant bus sets bus failure flag.
// R20: Controller keeps baud rate of 40 kbaud minimum.
// R21: Stuck dominant input disables driver, sets flag.
// R22: Driver stays off until cleared and re-enabled.
// R23: Window expiry discards counted wake pulses.

`timescale 1ns/100ps
`default_nettype none

module cantx_top #(
	parameter int WAKE_WINDOW_CYC = cantx_pkg::WAKE_WINDOW_CYC,
	parameter int TXD_DOM_TIMEOUT_CYC = cantx_pkg::TXD_DOM_TIMEOUT_CYC,
	parameter int BUS_CLAMP_TIMEOUT_CYC = cantx_pkg::BUS_CLAMP_TIMEOUT_CYC
) (
	input wire logic mclk,
	input wire logic reset,
	// Transmit input from the protocol controller, high is recessive.
	input wire logic txd,
	// Main differential receiver, high when the bus is dominant.
	input wire logic bus_diff_dom,
	// Low-power wake receiver, high when the bus is dominant.
	input wire logic wake_diff_dom,
	// Configuration levels from the serial register block.
	input wire logic [1:0] mode_sel,
	input wire logic mode_wr,
	input wire logic [1:0] slew_sel,
	input wire logic wake_en,
	input wire logic wake_single_pulse_select,
	// One-cycle pulse: software has read the flags.
	input wire logic flags_read,
	// Fault comparators.
	input wire logic low_line_gnd_cmp,
	input wire logic high_line_gnd_cmp,
	input wire logic low_line_batt_cmp,
	input wire logic high_line_batt_cmp,
	input wire logic low_line_rail_cmp,
	input wire logic high_line_rail_cmp,
	// Bus side controls.
	output logic rxd,
	output logic drv_en,
	output logic drv_dom,
	output logic [1:0] slew_rate,
	output logic bus_gnd_term,
	output logic split_en,
	output logic wake_rx_en,
	// Status.
	output logic int_n,
	output logic wake_flag,
	output logic bus_fault_flag,
	output logic [2:0] bus_fault_code,
	output logic bus_clamp_flag,
	output logic txd_perm_flag
);

	import cantx_pkg::*;

	// ************************************************************
	// Widths and state.
	// ************************************************************

	// Wider than any count that is compared.
	localparam int WIN_W = $clog2(WAKE_WINDOW_CYC + 1);
	localparam int PW = 8;
	localparam int TW = $clog2(TXD_DOM_TIMEOUT_CYC + 2);
	localparam int CW = $clog2(BUS_CLAMP_TIMEOUT_CYC + 2);

	// Whole state of the block; output fields feed ports directly.
	typedef struct packed {
		cantx_st_e st;
		logic read_seen;
		logic [1:0] pcnt;
		logic [WIN_W-1:0] win;
		logic [CMP_W-1:0] rec;
		logic [CMP_W-1:0] dom;
		logic was_dom;
		cantx_flt_e last;
		logic [2:0] conf;
		logic rxd;
		logic drv_en;
		logic drv_dom;
		logic [1:0] slew;
		logic gnd_term;
		logic split_en;
		logic wake_rx_en;
		logic int_n;
		logic wake_flag;
		logic fault_flag;
		cantx_flt_e fault_code;
		logic clamp_flag;
		logic perm_flag;
	} cantx_state_s;

	cantx_state_s state_q;
	cantx_state_s state_d;

	// Run lengths of wake pulses, transmit dominant and bus dominant.
	logic [PW-1:0] wake_len;
	logic [TW-1:0] txd_len;
	logic [CW-1:0] clamp_len;
	// Current comparator sample.
	logic [CMP_W-1:0] cmp_now;

	assign cmp_now = {high_line_rail_cmp, low_line_rail_cmp, high_line_batt_cmp,
		low_line_batt_cmp, high_line_gnd_cmp, low_line_gnd_cmp};

	// ************************************************************
	// Fault decode.
	// ************************************************************

	// Decodes one comparator pair; pairs are {high, low}.
	// For the ground pair a healthy bus reads high when recessive, so the
	// detect pattern is all-low; the other pairs detect on all-high.
	function automatic cantx_flt_e pair_decode(
		input logic [1:0] rec2,
		input logic [1:0] dom2,
		input logic gnd,
		input cantx_flt_e l_code,
		input cantx_flt_e h_code
	);
		cantx_flt_e r;
		r = FLT_NONE;
		if (gnd) begin
			if (rec2 == 2'h0) begin
				if (dom2 == 2'h2) begin
					r = l_code;
				end else if (dom2 == 2'h0) begin
					r = h_code;
				end
			end
		end else if (rec2 == 2'h3) begin
			if (dom2 == 2'h3) begin
				r = l_code;
			end else if (dom2 == 2'h2) begin
				r = h_code;
			end
		end
		return r;
	endfunction : pair_decode

	// ************************************************************
	// Run timers.
	// ************************************************************

	// Wake receiver is only looked at while it is enabled.
	cantx_run_timer #(
		.W(PW)
	) u_wake_tmr (
		.clk(mclk),
		.reset(reset),
		.run(wake_diff_dom & state_q.wake_rx_en),
		.count(wake_len)
	);

	// Transmit input dominant while the driver is on.
	cantx_run_timer #(
		.W(TW)
	) u_txd_tmr (
		.clk(mclk),
		.reset(reset),
		.run(~txd & state_q.drv_en),
		.count(txd_len)
	);

	// Bus held dominant, whatever the mode.
	cantx_run_timer #(
		.W(CW)
	) u_clamp_tmr (
		.clk(mclk),
		.reset(reset),
		.run(bus_diff_dom),
		.count(clamp_len)
	);

	// ************************************************************
	// Next-state logic.
	// ************************************************************

	// Mode sequencing, wake detection, diagnosis and flags.
	// Flags are sticky; a set in the same cycle as a read wins.
	always_comb begin
		logic valid_pulse;
		logic wake_evt;
		logic drv_on;
		cantx_flt_e f;
		valid_pulse = 1'b0;
		wake_evt = 1'b0;
		drv_on = 1'b0;
		f = FLT_NONE;
		state_d = state_q;
		state_d.int_n = 1'b1;

		// Flag reads clear; sets below override.
		if (flags_read) begin
			state_d.wake_flag = 1'b0;
			state_d.fault_flag = 1'b0;
			state_d.clamp_flag = 1'b0;
			state_d.perm_flag = 1'b0;
		end

		// R12 pulse length
		valid_pulse = (wake_len == PW'(WAKE_PULSE_MIN_CYC));

		// R11 three-pulse window
		if (state_q.pcnt != 2'h0) begin
			if (state_q.win == WIN_W'(WAKE_WINDOW_CYC)) begin
				// R23 window expiry restart
				state_d.pcnt = 2'h0;
				state_d.win = '0;
			end else begin
				state_d.win = state_q.win + 1'b1;
			end
		end
		if (wake_single_pulse_select) begin
			// R13 single long pulse
			wake_evt = (wake_len == PW'(WAKE_SINGLE_CYC));
			state_d.pcnt = 2'h0;
		end else if (valid_pulse && state_d.pcnt != 2'h0) begin
			// R11 count within window
			state_d.pcnt = state_d.pcnt + 1'b1;
			wake_evt = (state_d.pcnt == WAKE_PATTERN_PULSES);
		end else if (valid_pulse) begin
			state_d.pcnt = 2'h1;
			state_d.win = '0;
		end
		// R10 only while armed
		wake_evt = wake_evt & state_q.wake_rx_en;
		if (wake_evt || !state_q.wake_rx_en) begin
			state_d.pcnt = 2'h0;
			state_d.win = '0;
		end

		// Operating state.
		case (state_q.st)
			ST_STANDBY: begin
				if (mode_sel == MODE_SLEEP) begin
					state_d.st = ST_SLEEP;
				// R3 enable on recessive input
				end else if (mode_sel == MODE_TXRX && txd) begin
					state_d.st = ST_ACTIVE;
				end
			end
			ST_ACTIVE: begin
				drv_on = 1'b1;
				if (txd_len == TW'(TXD_DOM_TIMEOUT_CYC)) begin
					// R21 stuck dominant lockout
					state_d.st = ST_LOCKED;
					state_d.read_seen = 1'b0;
					state_d.perm_flag = 1'b1;
					drv_on = 1'b0;
				end else if (mode_sel == MODE_SLEEP) begin
					state_d.st = ST_SLEEP;
					drv_on = 1'b0;
				// R2 receive-only drops driver
				end else if (mode_sel != MODE_TXRX) begin
					state_d.st = ST_STANDBY;
					drv_on = 1'b0;
				end
			end
			ST_LOCKED: begin
				// R22 release to standby needs read, recessive input, fresh mode write; a fresh sleep mode write releases without them
				if (flags_read) begin
					state_d.read_seen = 1'b1;
				end
				if (mode_wr && mode_sel == MODE_SLEEP) begin
					state_d.st = ST_SLEEP;
				end else if (mode_wr && state_q.read_seen && txd) begin
					state_d.st = ST_STANDBY;
				end
			end
			ST_SLEEP: begin
				// R8 wake leaves sleep
				if (wake_evt) begin
					state_d.st = ST_WOKEN;
				// R9 back to bias
				end else if (mode_sel != MODE_SLEEP) begin
					state_d.st = ST_STANDBY;
				end
			end
			ST_WOKEN: begin
				if (mode_sel != MODE_SLEEP) begin
					state_d.st = ST_STANDBY;
				end
			end
			default: begin
				state_d.st = ST_STANDBY;
			end
		endcase

		// R8 flag and interrupt pulse
		if (wake_evt) begin
			state_d.wake_flag = 1'b1;
			state_d.int_n = 1'b0;
		end

		// R1 driver follows transmit input
		state_d.drv_en = drv_on;
		// R4 low input drives dominant
		state_d.drv_dom = drv_on & ~txd;
		// R7 sleep terminations
		state_d.gnd_term = (state_d.st == ST_SLEEP);
		state_d.split_en = (state_d.st != ST_SLEEP);
		// R10 wake receiver armed
		state_d.wake_rx_en = (state_d.st == ST_SLEEP) & wake_en;
		// R5 receive output polarity
		state_d.rxd = (state_d.st == ST_SLEEP) | ~bus_diff_dom;

		// R6 slew select, fastest default
		case (slew_sel)
			SLEW_MID: state_d.slew = SLEW_MID;
			SLEW_SLOW: state_d.slew = SLEW_SLOW;
			default: state_d.slew = SLEW_FAST;
		endcase

		// R17 sample each phase while driving
		if (state_q.drv_en && state_q.drv_dom) begin
			state_d.dom = cmp_now;
		end else if (state_q.drv_en) begin
			state_d.rec = cmp_now;
		end
		state_d.was_dom = state_q.drv_en & state_q.drv_dom;

		// One cycle ends when the driver leaves dominant.
		if (state_q.was_dom && !(state_q.drv_en && state_q.drv_dom)) begin
			// R14 ground pair
			f = pair_decode(state_q.rec[CMP_GND +: 2], state_q.dom[CMP_GND +: 2], 1'b1,
				FLT_L_GND, FLT_H_GND);
			// R15 battery pair
			if (f == FLT_NONE) begin
				f = pair_decode(state_q.rec[CMP_BATT +: 2], state_q.dom[CMP_BATT +: 2], 1'b0,
					FLT_L_BATT, FLT_H_BATT);
			end
			// R16 rail pair
			if (f == FLT_NONE) begin
				f = pair_decode(state_q.rec[CMP_RAIL +: 2], state_q.dom[CMP_RAIL +: 2], 1'b0,
					FLT_L_RAIL, FLT_H_RAIL);
			end
			// R18 five matching cycles
			if (f == FLT_NONE) begin
				state_d.conf = 3'h0;
			end else if (f != state_q.last) begin
				state_d.conf = 3'h1;
			end else if (state_q.conf != FAULT_CONFIRM_CYCLES) begin
				state_d.conf = state_q.conf + 1'b1;
			end
			state_d.last = f;
			if (f != FLT_NONE && state_d.conf == FAULT_CONFIRM_CYCLES) begin
				state_d.fault_flag = 1'b1;
				state_d.fault_code = f;
			end
		end

		// R19 clamp timeout
		if (clamp_len == CW'(BUS_CLAMP_TIMEOUT_CYC)) begin
			state_d.clamp_flag = 1'b1;
		end
	end

	// ************************************************************
	// State register.
	// ************************************************************

	// Reset leaves the bus recessive with bias on and all flags clear.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_q <= '0;
			state_q.st <= ST_STANDBY;
			state_q.rxd <= 1'b1;
			state_q.split_en <= 1'b1;
			state_q.int_n <= 1'b1;
			state_q.slew <= SLEW_FAST;
		end else begin
			state_q <= state_d;
		end
	end

	// ************************************************************
	// Outputs, all straight from the state register.
	// ************************************************************

	assign rxd = state_q.rxd;
	assign drv_en = state_q.drv_en;
	assign drv_dom = state_q.drv_dom;
	assign slew_rate = state_q.slew;
	assign bus_gnd_term = state_q.gnd_term;
	assign split_en = state_q.split_en;
	assign wake_rx_en = state_q.wake_rx_en;
	assign int_n = state_q.int_n;
	assign wake_flag = state_q.wake_flag;
	assign bus_fault_flag = state_q.fault_flag;
	assign bus_fault_code = state_q.fault_code;
	assign bus_clamp_flag = state_q.clamp_flag;
	assign txd_perm_flag = state_q.perm_flag;

endmodule : cantx_top

`default_nettype wire

/* File: rtl/cantx_pkg.sv */
/*
 * Constants, codes and types shared by the CAN transceiver control logic:
 * mode and slew codes, timing figures and their cycle counts, fault codes.
 * Assumes a single 125 MHz system clock drives all users of this package.
 */

package cantx_pkg;

	// ************************************************************
	// Clock and timing figures.
	// ************************************************************

	// System clock period in nanoseconds.
	localparam int CLK_PERIOD_NS = 8;

	// A wake dominant pulse counts only when longer than this.
	localparam int WAKE_PULSE_MIN_NS = 500;
	// Least time, so rounded up to whole cycles.
	localparam int WAKE_PULSE_MIN_CYC = (WAKE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Single-pulse wake needs a dominant pulse of this length.
	localparam int WAKE_SINGLE_NS = 2000;
	localparam int WAKE_SINGLE_CYC = (WAKE_SINGLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Three valid pulses must fit in this window (longest time, rounded down).
	localparam int WAKE_WINDOW_US = 120;
	localparam int WAKE_WINDOW_CYC = (WAKE_WINDOW_US * 1000) / CLK_PERIOD_NS;

	// Transmit input dominant timeout (shortest figure, rounded up).
	localparam int TXD_DOM_TIMEOUT_US = 300;
	localparam int TXD_DOM_TIMEOUT_CYC = (TXD_DOM_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Bus dominant clamp timeout; plain default value.
	localparam int BUS_CLAMP_TIMEOUT_US = 1000;
	localparam int BUS_CLAMP_TIMEOUT_CYC = (BUS_CLAMP_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Pulses for a pattern wake and cycles for a confirmed fault.
	localparam logic [1:0] WAKE_PATTERN_PULSES = 2'h3;
	localparam logic [2:0] FAULT_CONFIRM_CYCLES = 3'h5;

	// ************************************************************
	// Mode and slew codes.
	// ************************************************************

	localparam logic [1:0] MODE_TXRX = 2'h0;
	localparam logic [1:0] MODE_RXONLY = 2'h1;
	localparam logic [1:0] MODE_SLEEP = 2'h2;

	// Code zero is the fastest rate and the reset default.
	localparam logic [1:0] SLEW_FAST = 2'h0;
	localparam logic [1:0] SLEW_MID = 2'h1;
	localparam logic [1:0] SLEW_SLOW = 2'h2;

	// ************************************************************
	// Comparator sample layout and fault codes.
	// ************************************************************

	// Bit positions of the six comparators in a sample word.
	localparam int CMP_GND = 0;
	localparam int CMP_BATT = 2;
	localparam int CMP_RAIL = 4;
	localparam int CMP_W = 6;

	// Detected bus fault.
	typedef enum logic [2:0] {
		FLT_NONE, FLT_L_GND, FLT_H_GND, FLT_L_BATT, FLT_H_BATT, FLT_L_RAIL, FLT_H_RAIL
	} cantx_flt_e;

	// Transceiver operating state.
	typedef enum logic [2:0] {
		ST_STANDBY, ST_ACTIVE, ST_LOCKED, ST_SLEEP, ST_WOKEN
	} cantx_st_e;

endpackage : cantx_pkg

/* File: rtl/cantx_run_timer.sv */
/*
 * Saturating run-length counter: counts consecutive cycles with run high.
 * Assumes run is synchronous to clk; the count clears the cycle after run drops.
 */

`timescale 1ns/100ps
`default_nettype none

module cantx_run_timer #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic run,
	output logic [W-1:0] count
);

	// ************************************************************
	// State.
	// ************************************************************

	// Whole state of the timer.
	typedef struct packed {
		logic [W-1:0] cnt;
	} cantx_tmr_s;

	cantx_tmr_s state_q;
	cantx_tmr_s state_d;

	// Saturation keeps a stuck input from wrapping back to a short length.
	always_comb begin
		state_d = state_q;
		if (!run) begin
			state_d.cnt = '0;
		end else if (state_q.cnt != {W{1'b1}}) begin
			state_d.cnt = state_q.cnt + 1'b1;
		end
	end

	// Register the next state.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign count = state_q.cnt;

endmodule : cantx_run_timer

`default_nettype wire

/* File: sim/cantx_checker.sv */
/* Port checker for cantx_top: driver, receive, wake and flag timing.
   Assumes one clock mclk and the asynchronous active-high reset. */
`timescale 1ns/100ps
`default_nettype none
module cantx_checker
	import cantx_pkg::*;
#(
	parameter int WAKE_WINDOW_CYC = cantx_pkg::WAKE_WINDOW_CYC,
	parameter int TXD_DOM_TIMEOUT_CYC = cantx_pkg::TXD_DOM_TIMEOUT_CYC,
	parameter int BUS_CLAMP_TIMEOUT_CYC = cantx_pkg::BUS_CLAMP_TIMEOUT_CYC
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic txd,
	input wire logic bus_diff_dom,
	input wire logic [1:0] mode_sel,
	input wire logic mode_wr,
	input wire logic [1:0] slew_sel,
	input wire logic rxd,
	input wire logic drv_en,
	input wire logic drv_dom,
	input wire logic [1:0] slew_rate,
	input wire logic bus_gnd_term,
	input wire logic split_en,
	input wire logic wake_rx_en,
	input wire logic int_n,
	input wire logic wake_flag,
	input wire logic bus_fault_flag,
	input wire logic [2:0] bus_fault_code,
	input wire logic bus_clamp_flag,
	input wire logic txd_perm_flag
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// Dominant run length; wide enough for the full clamp timeout.
	logic [17:0] dom_run_q;
	// Transmit dominant run while driving; the lockout must not come sooner.
	logic [17:0] txd_run_q;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			dom_run_q <= 18'h0;
			txd_run_q <= 18'h0;
		end else begin
			dom_run_q <= bus_diff_dom ? dom_run_q + 18'h1 : 18'h0;
			txd_run_q <= (!txd && drv_en) ? txd_run_q + 18'h1 : 18'h0;
		end
	end
	// ************************************************************
	// Properties.
	// ************************************************************
	property p_rxd; (mode_sel != MODE_SLEEP)[*3] |-> rxd == !$past(bus_diff_dom); endproperty
	a_rxd: assert property (p_rxd) else $error("rxd does not mirror bus");
	property p_dom; drv_en[*2] |-> drv_dom == !$past(txd); endproperty
	a_dom: assert property (p_dom) else $error("drv_dom does not follow txd");
	property p_off; (mode_sel != MODE_TXRX && !mode_wr)[*3] |-> !drv_en && !drv_dom; endproperty
	a_off: assert property (p_off) else $error("driver on outside txrx");
	property p_on; $rose(drv_en) |-> $past(txd, 2) && $past(mode_sel, 2) == MODE_TXRX; endproperty
	a_on: assert property (p_on) else $error("driver enabled wrongly");
	property p_sleep; bus_gnd_term |-> !drv_en && !split_en; endproperty
	a_sleep: assert property (p_sleep) else $error("sleep outputs wrong");
	property p_arm; $fell(int_n) |-> $past(wake_rx_en); endproperty
	a_arm: assert property (p_arm) else $error("wake while disarmed");
	property p_int; $fell(int_n) |-> wake_flag ##1 int_n; endproperty
	a_int: assert property (p_int) else $error("wake pulse wrong");
	property p_perm;
		$rose(txd_perm_flag) |-> !$past(txd) && txd_run_q >= 18'(TXD_DOM_TIMEOUT_CYC) ##[0:1] !drv_en;
	endproperty
	a_perm: assert property (p_perm) else $error("stuck txd not handled");
	property p_lock; txd_perm_flag && $past(txd_perm_flag) |-> !drv_en; endproperty
	a_lock: assert property (p_lock) else $error("driver on while locked");
	property p_slew; !$past(reset) |-> slew_rate == (($past(slew_sel) == 2'h3) ? SLEW_FAST : $past(slew_sel));
	endproperty
	a_slew: assert property (p_slew) else $error("slew rate wrong");
	property p_code; bus_fault_flag |-> bus_fault_code != 3'h0; endproperty
	a_code: assert property (p_code) else $error("fault flag without code");
	property p_clamp; $rose(bus_clamp_flag) |-> dom_run_q >= 18'(BUS_CLAMP_TIMEOUT_CYC - 1); endproperty
	a_clamp: assert property (p_clamp) else $error("clamp flag too early");
	c_wake: cover property ($fell(int_n));
	c_fault: cover property ($rose(bus_fault_flag));
	c_lock: cover property ($rose(txd_perm_flag));
endmodule : cantx_checker
bind cantx_top cantx_checker #(.WAKE_WINDOW_CYC(WAKE_WINDOW_CYC), .TXD_DOM_TIMEOUT_CYC(TXD_DOM_TIMEOUT_CYC),
	.BUS_CLAMP_TIMEOUT_CYC(BUS_CLAMP_TIMEOUT_CYC)) u_cantx_checker (.mclk, .reset, .txd, .bus_diff_dom,
	.mode_sel, .mode_wr, .slew_sel, .rxd, .drv_en, .drv_dom, .slew_rate, .bus_gnd_term, .split_en,
	.wake_rx_en, .int_n, .wake_flag, .bus_fault_flag, .bus_fault_code, .bus_clamp_flag, .txd_perm_flag);
`default_nettype wire

/* File: sim/cantx_mcu_model.sv */
/* Protocol controller stand-in: sends bursts of one-bit dominant pulses.
   Assumes txd is sampled by the transceiver on rising mclk edges. */
`timescale 1ns/100ps
`default_nettype none
module cantx_mcu_model #(
	// baud floor
	// Bit time in cycles; far shorter than the slowest legal bit.
	parameter int BIT_CYC = 8
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic start,
	input wire logic [3:0] pulses,
	input wire logic stuck,
	output logic txd,
	output logic busy
);
	logic [3:0] left_q;
	logic [7:0] t_q;
	assign busy = left_q != 4'h0;
	// Idle is recessive; stuck models a shorted transmit line.
	assign txd = !stuck && !(busy && t_q < 8'(BIT_CYC));
	// One dominant bit then one recessive bit per pulse.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			left_q <= 4'h0;
			t_q <= 8'h0;
		end else if (start) begin
			left_q <= pulses;
			t_q <= 8'h0;
		end else if (busy) begin
			t_q <= (t_q == 8'(2 * BIT_CYC - 1)) ? 8'h0 : t_q + 8'h1;
			if (t_q == 8'(2 * BIT_CYC - 1)) begin
				left_q <= left_q - 4'h1;
			end
		end
	end
endmodule : cantx_mcu_model
`default_nettype wire

/* File: sim/tb.sv */
/* Testbench for cantx_top: modes, slew, diagnosis, lockout and wake.
   Assumes the design package is compiled first; one 125 MHz clock. */
`timescale 1ns/100ps
`default_nettype none
module tb;
	import cantx_pkg::*;
	logic mclk = 1'b0, reset = 1'b1, bus_ext = 1'b0, wake_diff_dom = 1'b0, mode_wr = 1'b0;
	logic wake_en = 1'b0, wsel = 1'b0, flags_read = 1'b0, start = 1'b0, stuck = 1'b0;
	logic [1:0] mode_sel = MODE_RXONLY, slew_sel = SLEW_FAST;
	logic [2:0] flt = 3'h0;
	logic [3:0] pulses = 4'h0;
	wire logic txd, busy, rxd, drv_en, drv_dom, bus_gnd_term, split_en, wake_rx_en, int_n;
	wire logic wake_flag, bus_fault_flag, bus_clamp_flag, txd_perm_flag;
	wire logic [1:0] slew_rate;
	wire logic [2:0] bus_fault_code;
	int err_count = 0, total_checks = 0, i;
	// Bus and comparators follow the driver; flt selects the short.
	wire logic dom = drv_en & drv_dom;
	wire logic bus_dom = dom | bus_ext;
	wire logic lg = !dom && flt != 3'h1 && flt != 3'h2;
	wire logic hg = flt != 3'h2 && (flt != 3'h1 || dom);
	wire logic lb = flt == 3'h3 || (flt == 3'h4 && !dom);
	wire logic hb = flt == 3'h3 || flt == 3'h4;
	wire logic lr = flt == 3'h5 || (flt == 3'h6 && !dom);
	wire logic hr = flt == 3'h5 || flt == 3'h6;
	cantx_top #(.WAKE_WINDOW_CYC(200), .TXD_DOM_TIMEOUT_CYC(100), .BUS_CLAMP_TIMEOUT_CYC(150)) u_cantx_top (
		.mclk, .reset, .txd, .bus_diff_dom(bus_dom), .wake_diff_dom, .mode_sel, .mode_wr, .slew_sel,
		.wake_en, .wake_single_pulse_select(wsel), .flags_read, .low_line_gnd_cmp(lg), .high_line_gnd_cmp(hg),
		.low_line_batt_cmp(lb), .high_line_batt_cmp(hb), .low_line_rail_cmp(lr), .high_line_rail_cmp(hr),
		.rxd, .drv_en, .drv_dom, .slew_rate, .bus_gnd_term, .split_en, .wake_rx_en, .int_n, .wake_flag,
		.bus_fault_flag, .bus_fault_code, .bus_clamp_flag, .txd_perm_flag);
	cantx_mcu_model u_cantx_mcu_model (.mclk, .reset, .start, .pulses, .stuck, .txd, .busy);
	always #4 mclk = ~mclk;
	// ************************************************************
	// Access tasks.
	// ************************************************************
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cyc
	task automatic chk1(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk1
	task automatic chk3(input logic [2:0] got, input logic [2:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk3
	task automatic rd;
		flags_read = 1'b1;
		cyc(1);
		flags_read = 1'b0;
		cyc(1);
	endtask : rd
	task automatic mode(input logic [1:0] m);
		mode_sel = m;
		mode_wr = 1'b1;
		cyc(1);
		mode_wr = 1'b0;
		cyc(3);
	endtask : mode
	// The controller sends n pulses; the wait is bounded.
	task automatic burst(input logic [3:0] n);
		pulses = n;
		start = 1'b1;
		cyc(1);
		start = 1'b0;
		for (int k = 0; k < 300 && busy; k++) begin
			cyc(1);
		end
		cyc(3);
	endtask : burst
	task automatic wpulse(input int len, input int gap);
		wake_diff_dom = 1'b1;
		cyc(len);
		wake_diff_dom = 1'b0;
		cyc(gap);
	endtask : wpulse
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_of_test
	// Watchdog: the tests need about 20 us.
	initial begin
		#100000;
		err_count++;
		$display("watchdog expired at %0t", $time);
		end_of_test();
	end
	// ************************************************************
	// Test sequence.
	// ************************************************************
	initial begin
		cyc(8);
		reset = 1'b0;
		cyc(2);
		chk3({1'b0, slew_rate}, 3'h0);
		chk1(drv_en, 1'b0);
		$display("test reset done");
		mode_sel = MODE_TXRX;
		stuck = 1'b1;
		cyc(4);
		chk1(drv_en, 1'b0);
		stuck = 1'b0;
		cyc(3);
		chk1(drv_en, 1'b1);
		stuck = 1'b1;
		cyc(2);
		chk1(drv_dom, 1'b1);
		chk1(rxd, 1'b0);
		stuck = 1'b0;
		cyc(2);
		chk1(drv_dom, 1'b0);
		chk1(rxd, 1'b1);
		for (i = 0; i < 4; i++) begin
			slew_sel = 2'(i);
			cyc(2);
			chk3({1'b0, slew_rate}, (i == 3) ? 3'h0 : 3'(i));
		end
		$display("test normal mode done");
		mode_sel = MODE_RXONLY;
		cyc(3);
		chk1(drv_en, 1'b0);
		stuck = 1'b1;
		bus_ext = 1'b1;
		cyc(2);
		chk1(drv_dom, 1'b0);
		chk1(rxd, 1'b0);
		stuck = 1'b0;
		cyc(138);
		chk1(bus_clamp_flag, 1'b0);
		cyc(20);
		chk1(bus_clamp_flag, 1'b1);
		bus_ext = 1'b0;
		rd();
		chk1(bus_clamp_flag, 1'b0);
		$display("test receive only done");
		mode_sel = MODE_TXRX;
		cyc(4);
		for (i = 1; i < 7; i++) begin
			flt = 3'(i);
			rd();
			burst(4'h4);
			chk1(bus_fault_flag, 1'b0);
			burst(4'h1);
			chk1(bus_fault_flag, 1'b1);
			chk3(bus_fault_code, 3'(i));
		end
		flt = 3'h0;
		$display("test diagnosis done");
		stuck = 1'b1;
		cyc(105);
		chk1(txd_perm_flag, 1'b1);
		chk1(drv_en, 1'b0);
		stuck = 1'b0;
		mode(MODE_TXRX);
		chk1(drv_en, 1'b0);
		rd();
		mode(MODE_TXRX);
		chk1(drv_en, 1'b1);
		$display("test lockout done");
		mode_sel = MODE_SLEEP;
		cyc(3);
		chk1(bus_gnd_term, 1'b1);
		chk1(split_en, 1'b0);
		wsel = 1'b1;
		wpulse(300, 4);
		chk1(wake_flag, 1'b0);
		wake_en = 1'b1;
		cyc(2);
		chk1(wake_rx_en, 1'b1);
		wpulse(240, 4);
		chk1(wake_flag, 1'b0);
		wake_diff_dom = 1'b1;
		cyc(245);
		chk1(wake_flag, 1'b0);
		for (i = 0; i < 20 && int_n; i++) begin
			cyc(1);
		end
		chk1(int_n, 1'b0);
		chk1(wake_flag, 1'b1);
		cyc(1);
		chk1(int_n, 1'b1);
		wake_diff_dom = 1'b0;
		mode_sel = MODE_TXRX;
		cyc(4);
		chk1(bus_gnd_term, 1'b0);
		chk1(drv_dom, 1'b0);
		chk1(split_en, 1'b1);
		$display("test single wake done");
		rd();
		wsel = 1'b0;
		mode_sel = MODE_SLEEP;
		cyc(3);
		for (i = 0; i < 3; i++) begin
			wpulse(60, 4);
		end
		chk1(wake_flag, 1'b0);
		wpulse(66, 4);
		wpulse(66, 150);
		wpulse(66, 4);
		chk1(wake_flag, 1'b0);
		wpulse(66, 4);
		wpulse(66, 4);
		chk1(wake_flag, 1'b1);
		$display("test pattern wake done");
		end_of_test();
	end
endmodule : tb
`default_nettype wire
